// File: rtl/ocpwm_channel.sv
// Purpose: output compare channel with pulse and pwm modes
// Assumes: timer count, period and advance strobes come from outside
// Notes: registers on a plain strobe port, read data one cycle later
//
// Overview of operation
// - continuous mode drives pin low, then pulses each compare cycle
// - pulse modes drive pin high on match with primary compare
// - pulse modes drive pin low on match with secondary compare
// - continuous mode sets flag on each secondary compare match that ends a pulse
// - timer wraps to zero at period match and keeps counting
// - pwm period lasts period value plus one timer counts
// - secondary copied into primary only at period match in pwm
// - primary compare is read-only while pwm is active
// - primary value at pwm enable sets first period duty
// - duty zero keeps pin low whole period
// - duty above period keeps pin high continuously
// - duty equal to period gives one low count per period
// - mode zero disables, mode six is pwm without fault
// - mode one drives pin low then high on compare match
// - fault status is read-only, hardware set in mode seven, cleared by a control write leaving it
// - only the first two channels raise a dma request
// - single pulse ends low with no further pulses until rewrite
`default_nettype none
module ocpwm_channel #(
    parameter int CHANNEL_INDEX = 0
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // timer sources
    input wire logic [15:0] count_a_i,
    input wire logic [15:0] period_a_i,
    input wire logic count_en_a_i,
    input wire logic [15:0] count_b_i,
    input wire logic [15:0] period_b_i,
    input wire logic count_en_b_i,
    // fault pin, active low
    input wire logic fault_n_i,
    // outputs
    output logic compare_output_pin_o,
    output logic compare_irq_flag_o,
    output logic dma_req_o
);
    typedef enum logic [2:0] {
        OCP_IDLE = 3'b001,
        OCP_ARMED = 3'b010,
        OCP_DONE = 3'b100
    } ocp_state_type;

    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] primary_reg;
    logic [15:0] primary_next;
    logic [15:0] secondary_reg;
    logic [15:0] secondary_next;
    logic pin_reg;
    logic pin_next;
    logic flag_reg;
    logic flag_next;
    logic dma_reg;
    logic dma_next;
    logic fault_reg;
    logic fault_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    ocp_state_type state_reg;
    ocp_state_type state_next;
    logic [15:0] tb_count;
    logic [15:0] tb_period;
    logic tb_tick;
    logic fault_act;
    logic fault_sync;
    // decoded register strobes
    logic wr_pri;
    logic wr_sec;
    logic wr_stat;
    logic [2:0] mode;
    logic ctrl_wr;
    logic pwm_mode;

    ocpwm_timebase u_timebase (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .tsel_i(ctrl_reg[ocpwm_pkg::TSEL_BIT]),
        .count_a_i(count_a_i),
        .period_a_i(period_a_i),
        .count_en_a_i(count_en_a_i),
        .count_b_i(count_b_i),
        .period_b_i(period_b_i),
        .count_en_b_i(count_en_b_i),
        .count_o(tb_count),
        .period_o(tb_period),
        .tick_o(tb_tick)
    );

    ocpwm_sync u_fault_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(fault_act),
        .sync_o(fault_sync)
    );

    // inverted ahead of the synchroniser so its reset value means no fault
    assign fault_act = !fault_n_i;

    function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    // 17-bit compare so a count of all ones cannot wrap to zero
    function automatic logic duty_high(input logic [15:0] cnt, input logic [15:0] duty);
        duty_high = ({1'b0, cnt} + 17'h00001) < {1'b0, duty};
    endfunction

    assign mode = ctrl_reg[2:0];
    assign pwm_mode = (mode == ocpwm_pkg::MODE_PWM) || (mode == ocpwm_pkg::MODE_PWM_FLT);
    assign ctrl_wr = reg_wr_i && addr_hit(reg_addr_i, ocpwm_pkg::ADDR_CTRL);
    assign wr_pri = reg_wr_i && addr_hit(reg_addr_i, ocpwm_pkg::ADDR_PRIMARY);
    assign wr_sec = reg_wr_i && addr_hit(reg_addr_i, ocpwm_pkg::ADDR_SECONDARY);
    assign wr_stat = reg_wr_i && addr_hit(reg_addr_i, ocpwm_pkg::ADDR_STATUS);

    // control and secondary compare writes
    always_comb begin
        ctrl_next = ctrl_reg;
        secondary_next = secondary_reg;
        if (ctrl_wr) begin
            // unimplemented bits are dropped so they read back zero
            ctrl_next = reg_wdata_i & ocpwm_pkg::CTRL_WMASK;
        end
        if (wr_sec) begin
            // duty buffer, may change at any time without a glitch
            secondary_next = reg_wdata_i;
        end
    end

    // read data stand for one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_next = 16'h0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ocpwm_pkg::ADDR_CTRL: rdata_next = ctrl_reg
                    | ({15'h0000, fault_reg} << ocpwm_pkg::FAULT_BIT);
                ocpwm_pkg::ADDR_PRIMARY: rdata_next = primary_reg;
                ocpwm_pkg::ADDR_SECONDARY: rdata_next = secondary_reg;
                ocpwm_pkg::ADDR_STATUS: rdata_next = {15'h0000, flag_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // compare engine
    always_comb begin
        logic hit_pri;
        logic hit_sec;
        logic hit_per;
        // compare only on cycles where the selected timer advanced
        hit_pri = tb_tick && (tb_count == primary_reg);
        hit_sec = tb_tick && (tb_count == secondary_reg);
        hit_per = tb_tick && (tb_count == tb_period);
        primary_next = primary_reg;
        pin_next = pin_reg;
        state_next = state_reg;
        flag_next = flag_reg;
        fault_next = fault_reg;
        dma_next = 1'b0;
        // flag clear by status write, a new event below wins
        if (wr_stat && reg_wdata_i[ocpwm_pkg::FLAG_BIT]) begin
            flag_next = 1'b0;
        end
        // pwm owns the duty register, software writes are dropped
        if (!pwm_mode && wr_pri) begin
            primary_next = reg_wdata_i;
        end
        if (ctrl_wr) begin
            // mode rewrite restarts the sequence, pin low
            pin_next = 1'b0;
            state_next = OCP_ARMED;
            if (reg_wdata_i[2:0] == ocpwm_pkg::MODE_OFF) begin
                state_next = OCP_IDLE;
            end
            // leaving fault mode is the only way to clear the fault bit
            if (reg_wdata_i[2:0] != ocpwm_pkg::MODE_PWM_FLT) begin
                fault_next = 1'b0;
            end
        end else begin
            unique case (mode)
                ocpwm_pkg::MODE_OFF: begin
                    pin_next = 1'b0;
                end
                ocpwm_pkg::MODE_FORCE_HIGH: begin
                    if (hit_pri) begin
                        pin_next = 1'b1;
                        flag_next = 1'b1;
                    end
                end
                ocpwm_pkg::MODE_FORCE_LOW: begin
                    if (hit_pri) begin
                        pin_next = 1'b0;
                        flag_next = 1'b1;
                    end
                end
                ocpwm_pkg::MODE_TOGGLE: begin
                    if (hit_pri) begin
                        pin_next = !pin_reg;
                        flag_next = 1'b1;
                    end
                end
                ocpwm_pkg::MODE_SINGLE, ocpwm_pkg::MODE_CONT: begin
                    if (state_reg == OCP_ARMED) begin
                        // trailing edge first, so equal compares still close a pulse
                        if (hit_sec && pin_reg) begin
                            pin_next = 1'b0;
                            flag_next = 1'b1;
                            if (mode == ocpwm_pkg::MODE_SINGLE) begin
                                state_next = OCP_DONE;
                            end
                        end else if (hit_pri) begin
                            pin_next = 1'b1;
                        end
                    end else begin
                        pin_next = 1'b0;
                    end
                end
                default: begin
                    // pwm: high from period start until count reaches duty
                    // a fault latches and holds the pin low until control is rewritten with a mode other than seven
                    if (mode == ocpwm_pkg::MODE_PWM_FLT && fault_sync) begin
                        fault_next = 1'b1;
                        flag_next = 1'b1;
                    end
                    // duty buffer still advances while a fault holds the pin
                    if (hit_per) begin
                        primary_next = secondary_reg;
                    end
                    if (fault_reg || fault_next) begin
                        pin_next = 1'b0;
                    end else if (hit_per) begin
                        // next period starts at count zero
                        pin_next = (secondary_reg != ocpwm_pkg::ZERO16);
                    end else if (tb_tick) begin
                        pin_next = duty_high(tb_count, primary_reg);
                    end
                end
            endcase
        end
        // one-cycle request on each rising flag, channels 0 and 1 only
        if (flag_next && !flag_reg && CHANNEL_INDEX < 2) begin
            dma_next = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= ocpwm_pkg::CTRL_RESET;
            secondary_reg <= 16'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            secondary_reg <= secondary_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            primary_reg <= 16'h0000;
            pin_reg <= 1'b0;
            flag_reg <= 1'b0;
            dma_reg <= 1'b0;
            fault_reg <= 1'b0;
            state_reg <= OCP_IDLE;
        end else begin
            primary_reg <= primary_next;
            pin_reg <= pin_next;
            flag_reg <= flag_next;
            dma_reg <= dma_next;
            fault_reg <= fault_next;
            state_reg <= state_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign compare_output_pin_o = pin_reg;
    assign compare_irq_flag_o = flag_reg;
    assign dma_req_o = dma_reg;
endmodule
`default_nettype wire

// File: rtl/ocpwm_pkg.sv
// Purpose: shared constants for the compare/pwm channel
// Assumes: 16-bit timebase, plain register port
// Notes: offsets are word indices on the register port
`default_nettype none
package ocpwm_pkg;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 4;
    // register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PRIMARY = 4'h1;
    localparam logic [3:0] ADDR_SECONDARY = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    // control field positions
    localparam int MODE_LSB = 0;
    localparam int TSEL_BIT = 3;
    localparam int FAULT_BIT = 4;
    localparam int IDLE_BIT = 13;
    localparam int FLAG_BIT = 0;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h200f;
    // mode codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_FORCE_HIGH = 3'h1;
    localparam logic [2:0] MODE_FORCE_LOW = 3'h2;
    localparam logic [2:0] MODE_TOGGLE = 3'h3;
    localparam logic [2:0] MODE_SINGLE = 3'h4;
    localparam logic [2:0] MODE_CONT = 3'h5;
    localparam logic [2:0] MODE_PWM = 3'h6;
    localparam logic [2:0] MODE_PWM_FLT = 3'h7;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
endpackage
`default_nettype wire

// File: rtl/ocpwm_sync.sv
// Purpose: three-stage synchroniser with agreement check
// Assumes: input is asynchronous to mclk_i
// Notes: output changes when stages two and three agree
`default_nettype none
module ocpwm_sync (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // data
    input wire logic async_i,
    output logic sync_o
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic out_reg;
    logic out_next;

    always_comb begin
        stage_next = {stage_reg[1:0], async_i};
        out_next = out_reg;
        if (stage_reg[1] == stage_reg[2]) begin
            out_next = stage_reg[2];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            stage_reg <= 3'h0;
            out_reg <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            out_reg <= out_next;
        end
    end

    assign sync_o = out_reg;
endmodule
`default_nettype wire

// File: rtl/ocpwm_timebase.sv
// Purpose: selects one of two external timebases and their advance strobes
// Assumes: timers count on mclk_i, period match wraps the timer
// Notes: a plain select, the channel qualifies the count itself
`default_nettype none
module ocpwm_timebase (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // timer sources
    input wire logic tsel_i,
    input wire logic [15:0] count_a_i,
    input wire logic [15:0] period_a_i,
    input wire logic count_en_a_i,
    input wire logic [15:0] count_b_i,
    input wire logic [15:0] period_b_i,
    input wire logic count_en_b_i,
    // selected view
    output logic [15:0] count_o,
    output logic [15:0] period_o,
    output logic tick_o
);
    always_comb begin
        count_o = tsel_i ? count_b_i : count_a_i;
        period_o = tsel_i ? period_b_i : period_a_i;
        tick_o = tsel_i ? count_en_b_i : count_en_a_i;
    end
endmodule
`default_nettype wire

// File: bench/ocpwm_channel_asserts.sv
// Purpose: port checker for the compare/pwm channel
// Assumes: shadow copies of control and compare registers
// Notes: bound to the channel from the bench top
`default_nettype none
module ocpwm_channel_asserts #(
    parameter int CHANNEL_INDEX = 0
) (
    // clock, reset, register port
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // timers and fault
    input wire logic [15:0] count_a_i,
    input wire logic [15:0] period_a_i,
    input wire logic count_en_a_i,
    input wire logic [15:0] count_b_i,
    input wire logic [15:0] period_b_i,
    input wire logic count_en_b_i,
    input wire logic fault_n_i,
    // outputs
    input wire logic compare_output_pin_o,
    input wire logic compare_irq_flag_o,
    input wire logic dma_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ctl_reg, ctl_next;
    logic [15:0] pri_reg, pri_next, sec_reg, sec_next, cnt;
    logic done_reg, done_next, en, cw, wrap, exp_hi, sec_nz, pwm;
    logic [2:0] md;
    assign md = ctl_reg[2:0];
    assign pwm = md[2:1] == 2'h3;
    assign cnt = ctl_reg[3] ? count_b_i : count_a_i;
    assign en = ctl_reg[3] ? count_en_b_i : count_en_a_i;
    assign wrap = en && cnt == (ctl_reg[3] ? period_b_i : period_a_i);
    assign cw = reg_wr_i && reg_addr_i == ocpwm_pkg::ADDR_CTRL;
    assign exp_hi = ({1'b0, cnt} + 17'h00001) < {1'b0, pri_reg};
    assign sec_nz = sec_reg != 16'h0000;
    always_comb begin
        ctl_next = cw ? reg_wdata_i[3:0] : ctl_reg;
        sec_next = sec_reg;
        pri_next = pri_reg;
        if (reg_wr_i && reg_addr_i == ocpwm_pkg::ADDR_SECONDARY) begin
            sec_next = reg_wdata_i;
        end
        if (pwm && wrap && !cw) begin
            pri_next = sec_reg;
        end else if (!pwm && reg_wr_i && reg_addr_i == ocpwm_pkg::ADDR_PRIMARY) begin
            pri_next = reg_wdata_i;
        end
        done_next = !cw && (done_reg || (md == 3'h4 && compare_output_pin_o && en
            && cnt == sec_reg));
    end
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctl_reg <= 4'h0;
            pri_reg <= 16'h0000;
            sec_reg <= 16'h0000;
            done_reg <= 1'b0;
        end else begin
            ctl_reg <= ctl_next;
            pri_reg <= pri_next;
            sec_reg <= sec_next;
            done_reg <= done_next;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    AST_CTRL_LOW: assert property (
        cw && reg_wdata_i[2:0] inside {3'h1, 3'h4, 3'h5} |=> !compare_output_pin_o)
        else $error("pin not low after control write");
    AST_OFF_QUIET: assert property (
        md == 3'h0 |=> !compare_output_pin_o && !$rose(compare_irq_flag_o))
        else $error("disabled channel active");
    AST_LEAD: assert property (
        md == 3'h5 && !compare_output_pin_o && en && cnt == pri_reg && !cw
        |=> compare_output_pin_o) else $error("no leading edge");
    AST_TRAIL: assert property (
        md == 3'h5 && compare_output_pin_o && en && cnt == sec_reg && !cw
        |=> !compare_output_pin_o && compare_irq_flag_o) else $error("no trailing edge");
    AST_SINGLE_DONE: assert property (
        md == 3'h4 && done_reg |-> !compare_output_pin_o) else $error("extra pulse");
    AST_FORCE: assert property (
        md == 3'h1 && en && cnt == pri_reg && !cw |=> compare_output_pin_o)
        else $error("pin not forced high");
    AST_PWM_LEVEL: assert property (
        md == 3'h6 && en && !wrap && !cw |=> compare_output_pin_o == $past(exp_hi))
        else $error("pwm level wrong");
    AST_PWM_WRAP: assert property (
        md == 3'h6 && wrap && !cw |=> compare_output_pin_o == $past(sec_nz))
        else $error("pwm period start wrong");
    AST_PRI_READ: assert property (
        reg_rd_i && reg_addr_i == ocpwm_pkg::ADDR_PRIMARY |=> reg_rdata_o == $past(pri_reg))
        else $error("primary compare value wrong");
    AST_DMA: assert property (
        dma_req_o == (CHANNEL_INDEX < 2 && $rose(compare_irq_flag_o)))
        else $error("dma request wrong");
    cover property (md == 3'h4 && done_reg);
    cover property (pwm && wrap && sec_reg > cnt);
    cover property ($rose(dma_req_o));
endmodule
`default_nettype wire

// File: bench/ocpwm_timer_model.sv
// Purpose: timer source and load meter facing the channel
// Assumes: timer advances every clock while running
// Notes: high_o holds the high count of the last full period
`default_nettype none
module ocpwm_timer_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // timer control
    input wire logic run_i,
    input wire logic [15:0] period_i,
    // compare pin load
    input wire logic pin_i,
    // timer view and meter
    output logic [15:0] count_o,
    output logic en_o,
    output logic [15:0] high_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] acc;
    assign en_o = run_i;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !run_i) begin
            count_o <= 16'h0000;
            acc <= 16'h0000;
            high_o <= 16'h0000;
        end else if (count_o == period_i) begin
            count_o <= 16'h0000;
            high_o <= acc + {15'h0000, pin_i};
            acc <= 16'h0000;
        end else begin
            count_o <= count_o + 16'h0001;
            acc <= acc + {15'h0000, pin_i};
        end
    end
endmodule
`default_nettype wire

// File: bench/ocpwm_channel_tb.sv
// Purpose: self-checking bench for the compare/pwm channel
// Assumes: timebase a from the timer model, timebase b held still
// Notes: timer period of 20 counts
`default_nettype none
module ocpwm_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PER = 16'h0013;
    logic mclk_i, sys_rst_i, reg_wr_i, reg_rd_i, run, fault_n_i, count_en_a_i, count_en_b_i;
    logic [3:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, count_a_i, period_a_i, count_b_i, period_b_i;
    logic compare_output_pin_o, compare_irq_flag_o, dma_req_o;
    logic [15:0] hi_w, hi;
    logic [1:0] pf;
    logic [15:0] duty [4] = '{16'h0000, 16'h0009, PER, 16'h0015};
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    ocpwm_channel #(.CHANNEL_INDEX(0)) dut_u (.*);
    ocpwm_timer_model tmr_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .run_i(run),
        .period_i(period_a_i), .pin_i(compare_output_pin_o), .count_o(count_a_i),
        .en_o(count_en_a_i), .high_o(hi_w));
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rc(input string n, input logic [3:0] a, input logic [15:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(n, reg_rdata_o, e);
        @(posedge mclk_i);
    endtask
    task automatic snap(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
        pf = {compare_output_pin_o, compare_irq_flag_o};
        hi = hi_w;
        @(posedge mclk_i);
    endtask
    // waits for the pin or a dma pulse, bounded
    task automatic await_hi(input bit dma);
        int n;
        n = 0;
        do begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (!(dma ? dma_req_o : compare_output_pin_o) && n < 40);
        chk("await", 16'(n < 40), 16'h0001);
        @(posedge mclk_i);
    endtask
    initial begin
        mclk_i = 1'b0;
        sys_rst_i = 1'b1;
        {reg_wr_i, reg_rd_i, run, count_en_b_i} = 4'h0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 16'h0000;
        fault_n_i = 1'b1;
        period_a_i = PER;
        count_b_i = 16'h0000;
        period_b_i = 16'h0000;
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rc("ctrl", ocpwm_pkg::ADDR_CTRL, ocpwm_pkg::CTRL_RESET);
        rc("pri", ocpwm_pkg::ADDR_PRIMARY, 16'h0000);
        rc("status", ocpwm_pkg::ADDR_STATUS, 16'h0000);
        rc("unmapped", 4'hf, 16'h0000);
        wr(ocpwm_pkg::ADDR_CTRL, 16'hfff8);
        rc("ctrl_bits", ocpwm_pkg::ADDR_CTRL, 16'h2008);
        wr(ocpwm_pkg::ADDR_PRIMARY, 16'h0005);
        wr(ocpwm_pkg::ADDR_SECONDARY, 16'h000a);
        run <= 1'b1;
        wr(ocpwm_pkg::ADDR_CTRL, 16'h0005);
        for (int i = 0; i < 3; i++) begin
            await_hi(1'b0);
            wr(ocpwm_pkg::ADDR_STATUS, 16'h0001);
            await_hi(1'b1);
        end
        snap(40);
        chk("pulse_width", hi, 16'h0005);
        wr(ocpwm_pkg::ADDR_CTRL, 16'h0004);
        await_hi(1'b0);
        snap(45);
        chk("single_after", {hi[14:0], pf[1]}, 16'h0000);
        wr(ocpwm_pkg::ADDR_CTRL, 16'h0001);
        snap(25);
        chk("force_high", {14'h0000, pf}, 16'h0003);
        wr(ocpwm_pkg::ADDR_CTRL, {13'h0000, ocpwm_pkg::MODE_TOGGLE});
        wr(ocpwm_pkg::ADDR_STATUS, 16'h0001);
        await_hi(1'b0);
        snap(20);
        chk("toggle", {14'h0000, pf}, 16'h0001);
        wr(ocpwm_pkg::ADDR_CTRL, {13'h0000, ocpwm_pkg::MODE_FORCE_LOW});
        wr(ocpwm_pkg::ADDR_STATUS, 16'h0001);
        snap(25);
        chk("force_low", {14'h0000, pf}, 16'h0001);
        wr(ocpwm_pkg::ADDR_CTRL, 16'h000d);
        wr(ocpwm_pkg::ADDR_STATUS, 16'h0001);
        snap(45);
        chk("tsel_b", {14'h0000, pf}, 16'h0000);
        run <= 1'b0;
        wr(ocpwm_pkg::ADDR_PRIMARY, 16'h0004);
        wr(ocpwm_pkg::ADDR_SECONDARY, 16'h0009);
        wr(ocpwm_pkg::ADDR_CTRL, 16'h0006);
        rc("pri_first", ocpwm_pkg::ADDR_PRIMARY, 16'h0004);
        run <= 1'b1;
        foreach (duty[i]) begin
            wr(ocpwm_pkg::ADDR_SECONDARY, duty[i]);
            snap(45);
            chk("pwm_high", hi, (duty[i] > PER) ? PER + 16'h0001 : duty[i]);
        end
        wr(ocpwm_pkg::ADDR_PRIMARY, 16'h0007);
        rc("pri_ro", ocpwm_pkg::ADDR_PRIMARY, 16'h0015);
        wr(ocpwm_pkg::ADDR_CTRL, {13'h0000, ocpwm_pkg::MODE_PWM_FLT});
        fault_n_i <= 1'b0;
        snap(8);
        rc("fault_set", ocpwm_pkg::ADDR_CTRL, 16'h0017);
        chk("fault_pin", {14'h0000, pf}, 16'h0001);
        fault_n_i <= 1'b1;
        wr(ocpwm_pkg::ADDR_CTRL, 16'h0000);
        rc("fault_clr", ocpwm_pkg::ADDR_CTRL, 16'h0000);
        wr(ocpwm_pkg::ADDR_STATUS, 16'h0001);
        snap(45);
        chk("off", {hi[13:0], pf}, 16'h0000);
        complete_run();
    end
endmodule
bind ocpwm_channel ocpwm_channel_asserts #(.CHANNEL_INDEX(CHANNEL_INDEX)) chk_u (.*);
`default_nettype wire
